// *** hw/flash_bus_cycle.sv ***
// Purpose: One asynchronous flash bus cycle, write or read, paced by core_clk
// Assumes: data_in synchronous to core_clk
// Notes:   Strobes and data come from flops, so no glitch reaches the flash
`timescale 1ns/1ps
`include "flash_host_cfg.svh"

module flash_bus_cycle #(
  parameter int SETUP_CYC = 1,
  parameter int PULSE_CYC = (`WE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int ACC_CYC   = (`READ_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int HOLD_CYC  = 1
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // Request side
  input  wire logic        start,
  input  wire logic        abort,
  input  wire logic        is_write,
  input  wire logic [19:0] addr,
  input  wire logic [7:0]  wdata,
  output logic             done,
  output logic [7:0]       rdata,
  // Flash pins
  output logic             ce_n,
  output logic             oe_n,
  output logic             we_n,
  output logic [19:0]      addr_q,
  output logic [7:0]       dout,
  output logic             data_oe,
  input  wire logic [7:0]  data_in
);
  import flash_host_pkg::*;

  localparam logic [7:0] SETUP_LD = 8'(SETUP_CYC - 1);
  localparam logic [7:0] PULSE_LD = 8'(PULSE_CYC - 1);
  localparam logic [7:0] ACC_LD   = 8'(ACC_CYC - 1);
  localparam logic [7:0] HOLD_LD  = 8'(HOLD_CYC - 1);

  cyc_state_e st_reg;
  logic [7:0] cnt_reg;
  logic       wr_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Cycle sequencer: chip enable first, strobe last, so the strobe edge latches
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st_reg  <= CY_IDLE;
      cnt_reg <= 8'h00;
      wr_reg  <= 1'b0;
      ce_n    <= 1'b1;
      oe_n    <= 1'b1;
      we_n    <= 1'b1;
      addr_q  <= 20'h00000;
      dout    <= 8'h00;
      data_oe <= 1'b0;
      done    <= 1'b0;
      rdata   <= 8'h00;
    end else begin
      done <= 1'b0;
      if (abort) begin
        st_reg  <= CY_IDLE;
        ce_n    <= 1'b1;
        oe_n    <= 1'b1;
        we_n    <= 1'b1;
        // Data stays one more cycle so a cut write never latches a floating bus
        data_oe <= !we_n;
      end else begin
        unique case (st_reg)
          CY_IDLE: begin
            if (start) begin
              addr_q  <= addr;
              dout    <= wdata;
              wr_reg  <= is_write;
              ce_n    <= 1'b0;
              data_oe <= is_write;
              cnt_reg <= SETUP_LD;
              st_reg  <= CY_SETUP;
            end else data_oe <= 1'b0;
          end
          CY_SETUP: begin
            if (cnt_reg == 8'h00) begin
              // Output enable stays high for a write so the flash accepts it
              if (wr_reg) we_n <= 1'b0;
              else oe_n <= 1'b0;
              cnt_reg <= wr_reg ? PULSE_LD : ACC_LD;
              st_reg  <= CY_PULSE;
            end else cnt_reg <= cnt_reg - 8'h01;
          end
          CY_PULSE: begin
            if (cnt_reg == 8'h00) begin
              we_n <= 1'b1;
              oe_n <= 1'b1;
              if (!wr_reg) rdata <= data_in;
              cnt_reg <= HOLD_LD;
              st_reg  <= CY_HOLD;
            end else cnt_reg <= cnt_reg - 8'h01;
          end
          CY_HOLD: begin
            // Data still driven past the strobe's rising edge
            if (cnt_reg == 8'h00) begin
              ce_n    <= 1'b1;
              data_oe <= 1'b0;
              done    <= 1'b1;
              st_reg  <= CY_IDLE;
            end else cnt_reg <= cnt_reg - 8'h01;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the pin timing
  a_write_inhibit_ok: assert property (@(posedge core_clk) disable iff (reset)
    !we_n |-> (oe_n && !ce_n)) else $error("write strobe low without ce low and oe high");
  a_we_min_width: assert property (@(posedge core_clk) disable iff (reset)
    $fell(we_n) |-> !we_n [*3]) else $error("write strobe pulse too short");
  a_addr_stable: assert property (@(posedge core_clk) disable iff (reset)
    (!ce_n && $past(!ce_n)) |-> $stable(addr_q)) else $error("address moved in cycle");
  a_data_hold: assert property (@(posedge core_clk) disable iff (reset)
    $rose(we_n) |-> (data_oe && $stable(dout))) else $error("data not held at strobe rise");
  a_no_contention: assert property (@(posedge core_clk) disable iff (reset)
    !oe_n |-> !data_oe) else $error("host drives data while flash outputs enabled");

endmodule // flash_bus_cycle

// *** hw/flash_host_cfg.svh ***
// Purpose: Named constants for the parallel flash host controller
// Assumes: 200 MHz core clock, byte-wide flash with 20-bit byte address
// Notes:   Timing figures are kept in their own units; cycle counts derive in the modules
`ifndef FLASH_HOST_CFG_SVH
`define FLASH_HOST_CFG_SVH

// Register offsets of the controller's own register port
`define REG_CMD          8'h00
`define REG_ADDR         8'h04
`define REG_DATA         8'h08
`define REG_CTRL         8'h0C
`define REG_STATUS       8'h10
`define REG_RDATA        8'h14

// Field positions
`define CMD_OP_MSB       2
`define CTRL_HV_BIT      0
`define CTRL_POLL_MSB    2
`define CTRL_POLL_LSB    1
`define ST_BUSY_BIT      0
`define ST_DONE_BIT      1
`define ST_FAIL_BIT      2
`define ST_READY_BIT     3
`define DQ_POLL_BIT      7
`define DQ_TOGGLE_BIT    6

// Command addresses and data of the flash command sequences
`define CMD_ADDR_A       20'h05555
`define CMD_ADDR_B       20'h02AAA
`define CMD_KEY1         8'hAA
`define CMD_KEY2         8'h55
`define CMD_PROGRAM      8'hA0
`define CMD_ERASE_SETUP  8'h80
`define CMD_CHIP_ERASE   8'h10
`define CMD_LOCKOUT      8'h40
`define CMD_ID_ENTRY     8'h90
`define CMD_ID_EXIT      8'hF0

// Sequence lengths in bus writes
`define LEN_PROGRAM      3'h4
`define LEN_SIX          3'h6
`define LEN_ID_ENTRY     3'h3
`define LEN_ID_EXIT      3'h1

// Timing figures
`define CLK_PERIOD_NS    5
`define NOISE_FILTER_NS  15
`define WE_PULSE_NS      50
`define READ_ACCESS_NS   90
`define RESET_PULSE_NS   500
`define BUSY_SETTLE_NS   100
`define ERASE_MAX_S      10
`define BYTE_PROG_TYP_US 10
`define PROG_TIMEOUT_MULT 100

`endif

// *** hw/flash_host_ctrl.sv ***
// Purpose: Host-side controller driving a byte-wide parallel flash by its pins
// Assumes: Pin inputs synchronous to core_clk; 12 V reset switch on the board
// Notes:   Software orders operations through a small register port
//
// What this block does
// - Host issues six-write chip erase sequence
// - Host issues four-write program; flash self-times
// - Host issues six-write lockout sequence
// - Host marks a sequence or poll cut by reset as failed, for software to reissue
// - Host leaves identification by exit command
// - Host uses the fixed command address/data pairs
// - Single F0 write exits identification
`timescale 1ns/1ps
`include "flash_host_cfg.svh"

module flash_host_ctrl #(
  parameter logic [31:0] ERASE_TIMEOUT_CYC =
    32'(64'(`ERASE_MAX_S) * 64'd1000000000 / 64'(`CLK_PERIOD_NS)),
  parameter logic [31:0] PROG_TIMEOUT_CYC =
    32'(`BYTE_PROG_TYP_US * `PROG_TIMEOUT_MULT * 1000 / `CLK_PERIOD_NS)
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  // Flash control pins
  output logic             flash_ce_n,
  output logic             flash_oe_n,
  output logic             flash_we_n,
  output logic             flash_reset_n,
  output logic             flash_hv_en,
  input  wire logic        ready_busy_in,
  // Flash address and data pins
  output logic [19:0]      byte_address,
  output logic [7:0]       flash_dq_out,
  output logic             flash_dq_oe,
  input  wire logic [7:0]  flash_dq_in
);
  import flash_host_pkg::*;

  localparam logic [7:0] RESET_LD  =
    8'((`RESET_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS - 1);
  localparam logic [7:0] SETTLE_LD =
    8'((`BUSY_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS - 1);

  main_state_e st_reg;
  op_e         op_reg;
  logic [2:0]  idx_reg;
  logic [19:0] tgt_reg;
  logic [7:0]  data_reg;
  logic [2:0]  ctrl_reg;
  logic        done_reg;
  logic        fail_reg;
  logic [7:0]  rbyte_reg;
  logic [31:0] timer_reg;
  logic [7:0]  wait_reg;
  logic        prev_t_reg;
  logic        have_prev_reg;
  logic        cyc_start_reg;
  logic        cyc_write_reg;
  logic [19:0] cyc_addr_reg;
  logic [7:0]  cyc_data_reg;
  logic        cyc_done;
  logic [7:0]  cyc_rdata;
  logic        cmd_wr;
  logic        abort;
  op_e         new_op;
  logic [27:0] word;
  logic [2:0]  last_idx;
  logic        timed_out;

  ////////////////////////////////////////////////////////////////////////////
  // Command sequence table: address and data of each write
  function automatic logic [27:0] seq_word(op_e op, logic [2:0] idx,
                                           logic [19:0] tgt, logic [7:0] d);
    logic [7:0] third;
    third = (op == OP_PROGRAM) ? `CMD_PROGRAM :
            (op == OP_ID_ENTRY) ? `CMD_ID_ENTRY : `CMD_ERASE_SETUP;
    if (op == OP_ID_EXIT) return {`CMD_ADDR_A, `CMD_ID_EXIT};
    unique case (idx)
      3'h0:    return {`CMD_ADDR_A, `CMD_KEY1};
      3'h1:    return {`CMD_ADDR_B, `CMD_KEY2};
      3'h2:    return {`CMD_ADDR_A, third};
      3'h3:    return (op == OP_PROGRAM) ? {tgt, d} : {`CMD_ADDR_A, `CMD_KEY1};
      3'h4:    return {`CMD_ADDR_B, `CMD_KEY2};
      default: return {`CMD_ADDR_A, (op == OP_ERASE) ? `CMD_CHIP_ERASE : `CMD_LOCKOUT};
    endcase
  endfunction

  // Number of writes in each sequence, less one
  function automatic logic [2:0] seq_last(op_e op);
    unique case (op)
      OP_PROGRAM:  return `LEN_PROGRAM - 3'h1;
      OP_ERASE,
      OP_LOCKOUT:  return `LEN_SIX - 3'h1;
      OP_ID_ENTRY: return `LEN_ID_ENTRY - 3'h1;
      default:     return `LEN_ID_EXIT - 3'h1;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Decode of the command register write and sequence lookups
  assign cmd_wr    = reg_wr && (reg_addr == `REG_CMD);
  assign new_op    = op_e'(reg_wdata[`CMD_OP_MSB:0]);
  assign abort     = cmd_wr && (new_op == OP_RESET);
  assign word      = seq_word(op_reg, idx_reg + 3'h1, tgt_reg, data_reg);
  assign last_idx  = seq_last(op_reg);
  assign timed_out = timer_reg >= ((op_reg == OP_PROGRAM) ? PROG_TIMEOUT_CYC
                                                          : ERASE_TIMEOUT_CYC);
  assign flash_hv_en = ctrl_reg[`CTRL_HV_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Address, data and control registers written by software
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      tgt_reg  <= 20'h00000;
      data_reg <= 8'h00;
      ctrl_reg <= 3'h0;
    end else if (reg_wr) begin
      if (reg_addr == `REG_ADDR) tgt_reg <= reg_wdata[19:0];
      if (reg_addr == `REG_DATA) data_reg <= reg_wdata[7:0];
      if (reg_addr == `REG_CTRL) ctrl_reg <= reg_wdata[`CTRL_POLL_MSB:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe; unmapped offsets read zero
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `REG_ADDR:   reg_rdata <= {12'h000, tgt_reg};
        `REG_DATA:   reg_rdata <= {24'h000000, data_reg};
        `REG_CTRL:   reg_rdata <= {29'h00000000, ctrl_reg};
        `REG_STATUS: reg_rdata <= {28'h0000000, ready_busy_in, fail_reg, done_reg,
                                   st_reg != ST_IDLE};
        `REG_RDATA:  reg_rdata <= {24'h000000, rbyte_reg};
        default:     reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operation sequencer; non-reset orders while busy are dropped
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st_reg        <= ST_IDLE;
      op_reg        <= OP_NONE;
      idx_reg       <= 3'h0;
      done_reg      <= 1'b0;
      fail_reg      <= 1'b0;
      rbyte_reg     <= 8'h00;
      timer_reg     <= 32'h00000000;
      wait_reg      <= 8'h00;
      prev_t_reg    <= 1'b0;
      have_prev_reg <= 1'b0;
      flash_reset_n <= 1'b1;
      cyc_start_reg <= 1'b0;
      cyc_write_reg <= 1'b0;
      cyc_addr_reg  <= 20'h00000;
      cyc_data_reg  <= 8'h00;
    end else begin
      cyc_start_reg <= 1'b0;
      if (abort) begin
        // A command sequence or poll cut short is reported failed so software repeats it; a cut read is not
        fail_reg      <= (st_reg == ST_POLL) || (st_reg == ST_SEQ);
        done_reg      <= 1'b0;
        op_reg        <= OP_RESET;
        flash_reset_n <= 1'b0;
        wait_reg      <= RESET_LD;
        st_reg        <= ST_RESET;
      end else begin
        unique case (st_reg)
          ST_IDLE: begin
            if (cmd_wr && new_op != OP_NONE) begin
              op_reg        <= new_op;
              done_reg      <= 1'b0;
              fail_reg      <= 1'b0;
              idx_reg       <= 3'h0;
              cyc_start_reg <= 1'b1;
              cyc_write_reg <= new_op != OP_READ;
              {cyc_addr_reg, cyc_data_reg} <= (new_op == OP_READ) ? {tgt_reg, 8'h00}
                : seq_word(new_op, 3'h0, tgt_reg, data_reg);
              st_reg        <= (new_op == OP_READ) ? ST_READ : ST_SEQ;
            end
          end
          ST_SEQ: begin
            // Writes are issued whole and in order; only a reset order breaks a sequence
            if (cyc_done) begin
              if (idx_reg == last_idx) begin
                if (op_reg == OP_PROGRAM || op_reg == OP_ERASE || op_reg == OP_LOCKOUT) begin
                  timer_reg     <= 32'h00000000;
                  wait_reg      <= SETTLE_LD;
                  have_prev_reg <= 1'b0;
                  st_reg        <= ST_POLL;
                end else begin
                  done_reg <= 1'b1;
                  st_reg   <= ST_IDLE;
                end
              end else begin
                idx_reg       <= idx_reg + 3'h1;
                cyc_start_reg <= 1'b1;
                {cyc_addr_reg, cyc_data_reg} <= word;
              end
            end
          end
          ST_READ: begin
            if (cyc_done) begin
              rbyte_reg <= cyc_rdata;
              done_reg  <= 1'b1;
              st_reg    <= ST_IDLE;
            end
          end
          ST_POLL: begin
            timer_reg <= timer_reg + 32'h00000001;
            if (wait_reg != 8'h00) begin
              // Give the flash time to pull busy before watching it
              wait_reg <= wait_reg - 8'h01;
              if (wait_reg == 8'h01 && ctrl_reg[`CTRL_POLL_MSB:`CTRL_POLL_LSB] != POLL_READY) begin
                cyc_start_reg <= 1'b1;
                cyc_write_reg <= 1'b0;
                cyc_addr_reg  <= tgt_reg;
              end
            end else if (ctrl_reg[`CTRL_POLL_MSB:`CTRL_POLL_LSB] == POLL_READY) begin
              if (ready_busy_in) begin
                done_reg <= 1'b1;
                st_reg   <= ST_IDLE;
              end else if (timed_out) begin
                fail_reg <= 1'b1;
                st_reg   <= ST_IDLE;
              end
            end else if (cyc_done) begin
              prev_t_reg    <= cyc_rdata[`DQ_TOGGLE_BIT];
              have_prev_reg <= 1'b1;
              rbyte_reg     <= cyc_rdata;
              // Polling bit only means something for a byte program
              if ((ctrl_reg[`CTRL_POLL_MSB:`CTRL_POLL_LSB] == POLL_DATA && op_reg == OP_PROGRAM)
                  ? (cyc_rdata[`DQ_POLL_BIT] == data_reg[`DQ_POLL_BIT])
                  : (have_prev_reg && cyc_rdata[`DQ_TOGGLE_BIT] == prev_t_reg)) begin
                done_reg <= 1'b1;
                st_reg   <= ST_IDLE;
              end else if (timed_out) begin
                fail_reg <= 1'b1;
                st_reg   <= ST_IDLE;
              end else begin
                cyc_start_reg <= 1'b1;
              end
            end
          end
          ST_RESET: begin
            // Releasing reset lets the flash follow the idle control pins
            if (wait_reg == 8'h00) begin
              flash_reset_n <= 1'b1;
              done_reg      <= 1'b1;
              st_reg        <= ST_IDLE;
            end else wait_reg <= wait_reg - 8'h01;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin timing engine
  flash_bus_cycle u_cycle (
    .core_clk (core_clk),
    .reset    (reset),
    .start    (cyc_start_reg),
    .abort    (abort),
    .is_write (cyc_write_reg),
    .addr     (cyc_addr_reg),
    .wdata    (cyc_data_reg),
    .done     (cyc_done),
    .rdata    (cyc_rdata),
    .ce_n     (flash_ce_n),
    .oe_n     (flash_oe_n),
    .we_n     (flash_we_n),
    .addr_q   (byte_address),
    .dout     (flash_dq_out),
    .data_oe  (flash_dq_oe),
    .data_in  (flash_dq_in)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks on sequencing
  a_first_key: assert property (@(posedge core_clk) disable iff (reset)
    (cmd_wr && st_reg == ST_IDLE && new_op inside {OP_PROGRAM, OP_ERASE, OP_LOCKOUT})
    |=> (cyc_addr_reg == `CMD_ADDR_A && cyc_data_reg == `CMD_KEY1))
    else $error("sequence does not open with the first key");
  a_reset_pin: assert property (@(posedge core_clk) disable iff (reset)
    abort |=> !flash_reset_n [*8]) else $error("reset pulse too short");
  a_abort_fail: assert property (@(posedge core_clk) disable iff (reset)
    (abort && st_reg inside {ST_SEQ, ST_POLL}) |=> fail_reg)
    else $error("cut operation not failed");
  a_no_write_in_reset: assert property (@(posedge core_clk) disable iff (reset)
    !flash_reset_n |-> flash_we_n) else $error("write strobe during reset");

endmodule // flash_host_ctrl

// *** hw/flash_host_pkg.sv ***
// Purpose: Types shared by the flash host controller modules
// Assumes: Constants come from flash_host_cfg.svh
// Notes:   One-hot state codes are written out
package flash_host_pkg;

  typedef enum logic [2:0] {
    OP_READ     = 3'h0,
    OP_PROGRAM  = 3'h1,
    OP_ERASE    = 3'h2,
    OP_LOCKOUT  = 3'h3,
    OP_ID_ENTRY = 3'h4,
    OP_ID_EXIT  = 3'h5,
    OP_RESET    = 3'h6,
    OP_NONE     = 3'h7
  } op_e;

  typedef enum logic [1:0] {
    POLL_TOGGLE = 2'h0,
    POLL_DATA   = 2'h1,
    POLL_READY  = 2'h2,
    POLL_SPARE  = 2'h3
  } poll_e;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_SEQ   = 5'h02,
    ST_READ  = 5'h04,
    ST_POLL  = 5'h08,
    ST_RESET = 5'h10
  } main_state_e;

  typedef enum logic [3:0] {
    CY_IDLE  = 4'h1,
    CY_SETUP = 4'h2,
    CY_PULSE = 4'h4,
    CY_HOLD  = 4'h8
  } cyc_state_e;

endpackage

// *** test/flash_dev_model.sv ***
// Purpose: Behavioural byte-wide flash seen from the host controller pins
// Assumes: Pins driven from core_clk flops; DQ has no pull, so it wanders when released
// Notes:   Short internal timer so the run stays brief
`timescale 1ns/1ps
module flash_dev_model #(
  parameter logic TOP_BOOT  = 1'b0,
  parameter int   PROG_CYC  = 200,
  parameter int   ERASE_CYC = 1000
) (
  // Timer clock
  input  wire logic        core_clk,
  // Control pins
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic        reset_n,
  input  wire logic        hv_en,
  output logic             ready_busy,
  // Address and data
  input  wire logic [19:0] byte_address,
  input  wire logic [7:0]  dq_host,
  input  wire logic        dq_oe,
  output logic [7:0]       dq_dev = 8'h00
);
  logic [7:0]  mem [int];
  logic [19:0] la;
  logic [7:0]  ld, last;
  logic        wr_n;
  logic        locked = 1'b0;
  logic        id_mode = 1'b0;
  logic        tog = 1'b0;
  int          step, busy;
  realtime     t_low = 0.0;
  // Write strobe needs both enables low and oe high
  assign wr_n = ce_n | we_n | ~oe_n;
  // Driven both ways: low while the timer runs, high once it reaches zero
  assign ready_busy = (busy > 0) ? 1'b0 : 1'b1;
  function automatic logic prot(logic [19:0] a);
    return locked && !hv_en && (TOP_BOOT ? a >= 20'hFC000 : a <= 20'h03FFF);
  endfunction
  function automatic logic [7:0] peek(logic [19:0] a);
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction
  always @(negedge wr_n) begin
    la = byte_address;
    t_low = $realtime;
  end
  // Data latch and command decode; ignored while busy or after a glitch
  always @(posedge wr_n) begin
    ld = dq_oe ? dq_host : ~dq_host;
    if (busy == 0 && reset_n === 1'b1 && $realtime - t_low >= 15.0) begin
      // Program data comes first, so a data byte of F0 is still programmed
      if (step == 3) begin
        if (!prot(la)) mem[la] = peek(la) & ld;
        last = ld;
        busy = PROG_CYC;
        step = 0;
      end else if (ld == 8'hF0) begin
        id_mode = 0;
        step = 0;
      end else if (la == 20'h05555 && ld == 8'hAA && (step == 0 || step == 4)) step++;
      else if (la == 20'h02AAA && ld == 8'h55 && (step == 1 || step == 5)) step++;
      else if (la == 20'h05555 && step == 2 && ld == 8'hA0) step = 3;
      else if (la == 20'h05555 && step == 2 && ld == 8'h80) step = 4;
      else if (la == 20'h05555 && step == 2 && ld == 8'h90) begin
        id_mode = 1;
        step = 0;
      end else if (la == 20'h05555 && step == 6 && ld == 8'h10) begin
        foreach (mem[a]) if (!prot(a)) mem[a] = 8'hFF;
        busy = ERASE_CYC;
        step = 0;
      end else if (la == 20'h05555 && step == 6 && ld == 8'h40) begin
        locked = 1;
        busy = PROG_CYC;
        step = 0;
      end else step = 0;
    end
  end
  // Internal timer; reset low halts the operation
  always @(posedge core_clk) begin
    if (reset_n === 1'b0) begin
      busy = 0;
      step = 0;
    end else if (busy > 0) busy--;
  end
  always @(negedge oe_n) if (busy > 0) tog = ~tog;
  // Read path; a released bus keeps changing so no stale byte survives
  always @(posedge core_clk) begin
    if (!ce_n && !oe_n && we_n && reset_n) begin
      if (id_mode && byte_address == (TOP_BOOT ? 20'hF3002 : 20'h00002)) dq_dev <= {7'h0, locked};
      else if (busy > 0) dq_dev <= {~last[7], tog, 6'h00};
      else dq_dev <= peek(byte_address);
    end else dq_dev <= ~dq_dev;
  end
endmodule  // flash_dev_model

// *** test/tb_flash_host_ctrl.sv ***
// Purpose: Self-checking bench for the flash host controller
// Assumes: Shortened timeouts, model timer well inside them
// Notes:   Poll mode is drawn at random for every operation
`timescale 1ns/1ps
`include "flash_host_cfg.svh"
module tb_flash_host_ctrl;
  import flash_host_pkg::*;
  logic        core_clk, reset, reg_wr, reg_rd, ce_n, oe_n, we_n, rst_n, hv_pin, rdy, hv, dq_oe;
  logic [7:0]  reg_addr, dq_out, dq_in, d1, d2;
  logic [31:0] reg_wdata, reg_rdata, v;
  logic [19:0] baddr, a1;
  int          fail_count, n_checks, i;
  flash_host_ctrl #(.ERASE_TIMEOUT_CYC(32'd2000), .PROG_TIMEOUT_CYC(32'd500)) dut_u (
    .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_ce_n(ce_n),
    .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_reset_n(rst_n), .flash_hv_en(hv_pin),
    .ready_busy_in(rdy), .byte_address(baddr), .flash_dq_out(dq_out), .flash_dq_oe(dq_oe),
    .flash_dq_in(dq_in));
  flash_dev_model dev_u (.core_clk(core_clk), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .reset_n(rst_n), .hv_en(hv_pin), .ready_busy(rdy), .byte_address(baddr),
    .dq_host(dq_out), .dq_oe(dq_oe), .dq_dev(dq_in));
  // Programming a used byte can only clear bits
  function automatic logic [7:0] exp_prog(input logic [7:0] old, input logic [7:0] d);
    return old & d;
  endfunction
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // Data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic op(input op_e c, input logic [19:0] a, input logic [7:0] d, output logic [31:0] st);
    wr(`REG_ADDR, {12'h0, a});
    wr(`REG_DATA, {24'h0, d});
    wr(`REG_CTRL, {29'h0, 2'($urandom % 3), hv});
    wr(`REG_CMD, {29'h0, c});
    for (int k = 0; k < 4000; k++) begin
      rd(`REG_STATUS, st);
      if (st[`ST_BUSY_BIT] === 1'b0) break;
    end
    if (st[`ST_BUSY_BIT] !== 1'b0) begin
      chk("busy wait", 0, 1);
      results();
    end
  endtask
  task automatic rdf(input logic [19:0] a, input logic [7:0] e);
    op(OP_READ, a, 8'h00, v);
    rd(`REG_RDATA, v);
    chk("read data", {24'h0, e}, v);
  endtask
  initial begin
    {reset, reg_wr, reg_rd, reg_addr, reg_wdata, hv, fail_count, n_checks} = '0;
    reset = 1'b1;
    void'($urandom(32'h0A40));
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    rd(8'hFC, v);
    chk("unmapped", 0, v);
    rd(`REG_STATUS, v);
    chk("status reset", 32'h8, v);
    for (i = 0; i < 4; i++) begin
      a1 = 20'(32'h10000 * (i + 1) + ($urandom % 32'h10000));
      d1 = 8'($urandom);
      d2 = {d1[7], 7'($urandom)};
      op(OP_PROGRAM, a1, d1, v);
      chk("prog status", 32'hA, v);
      rdf(a1, d1);
      op(OP_PROGRAM, a1, d2, v);
      rdf(a1, exp_prog(d1, d2));
    end
    op(OP_LOCKOUT, 20'h0, 8'h00, v);
    chk("lock status", 32'hA, v);
    op(OP_PROGRAM, 20'h00010, 8'hA5, v);
    rdf(20'h00010, 8'hFF);
    op(OP_ID_ENTRY, 20'h0, 8'h00, v);
    rdf(20'h00002, 8'h01);
    op(OP_ID_EXIT, 20'h0, 8'h00, v);
    rdf(20'h00002, 8'hFF);
    hv = 1'b1;
    op(OP_PROGRAM, 20'h03FFF, 8'hA5, v);
    rdf(20'h03FFF, 8'hA5);
    hv = 1'b0;
    op(OP_PROGRAM, 20'h03FFF, 8'h80, v);
    rdf(20'h03FFF, 8'hA5);
    op(OP_ERASE, 20'h0, 8'h00, v);
    chk("erase status", 32'hA, v);
    rdf(a1, 8'hFF);
    rdf(20'h03FFF, 8'hA5);
    wr(`REG_CMD, 32'h1);
    op(OP_RESET, a1, 8'h3C, v);
    chk("reset status", 32'hE, v);
    op(OP_PROGRAM, a1, 8'h3C, v);
    rdf(a1, 8'h3C);
    rd(`REG_ADDR, v);
    chk("addr readback", {12'h0, a1}, v);
    results();
  end
endmodule  // tb_flash_host_ctrl
